// ===== hw/irsp_pkg.sv
// constants, types and opcode decoding for the serial command port
// Summary of operation
// - port is slave only, host drives clock
// - frame is opcode, address, sixteen data bits
// - serial_in sampled on rising serial clock edges
// - write frames echo input eight clocks later
// - chip select rising early discards the command
// - read answer: opcode echo, then data, no address
// - read data sampled from the 25th rising edge
// - decode register store and register read opcodes
// - decode eeprom word write, wipe and read
// - decode bulk eeprom write and bulk erase
// - object temperature at 09h, ambient at 0Ah
// - temperature word: data, high, low, fatal, zero
// - ambient over maximum: high flag, data all ones
// - ambient under minimum: low flag, data zeros
// - uncorrectable eeprom fault sets the fatal flag
// - twelve bit code maps linearly onto range
// - B200h to 10h unlocks, freezes temperature updates
// - 0065h to 18h enables the programming pump
// - sixteen sixteen-bit eeprom words for user storage
package irsp_pkg;
  localparam int SHIFT_W = 32;
  localparam int ECHO_TAP = 7;
  localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
  localparam logic [5:0] CNT_ECHO_FIRST = 6'h08;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h0F;
  localparam logic [5:0] CNT_ADDR_ECHO_FIRST = 6'h10;
  localparam logic [5:0] CNT_RD_LOAD = 6'h18;
  localparam logic [5:0] CNT_FRAME_LAST = 6'h1F;
  localparam logic [5:0] CNT_RD_LAST = 6'h27;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [7:0] ADDR_OBJ_TEMP = 8'h09;
  localparam logic [7:0] ADDR_AMB_TEMP = 8'h0A;
  localparam logic [7:0] ADDR_EE_UNLOCK = 8'h10;
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h18;
  localparam logic [15:0] KEY_EE_UNLOCK = 16'hB200;
  localparam logic [15:0] KEY_PUMP_ON = 16'h0065;
  localparam int EE_WORDS = 16;
  localparam logic [7:0] EE_USER_BASE = 8'h08;
  localparam logic [7:0] EE_LIMIT = 8'h10;
  localparam logic [15:0] EE_ERASED = 16'h0000;
  localparam logic [11:0] TEMP_ALL_ONES = 12'hFFF;
  localparam logic [11:0] TEMP_ALL_ZERO = 12'h000;
  localparam int SCLK_MIN_PERIOD_NS = 8000;
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int SCLK_MIN_SYS_CYCLES = (SCLK_MIN_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) /
                                       SYS_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_REG_STORE,
    OP_REG_READ,
    OP_EE_WRITE,
    OP_EE_WIPE,
    OP_EE_READ,
    OP_BULK_WRITE,
    OP_BULK_ERASE
  } irsp_op_type;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] addr;
    logic [15:0] data;
  } irsp_cmd_type;

  typedef struct packed {
    logic [11:0] data;
    logic high;
    logic low;
  } irsp_meas_type;

  function automatic irsp_op_type decode_op(input logic [7:0] code);
    irsp_op_type res;
    res = OP_NONE;
    casez (code)
      8'b?101?0??: res = OP_REG_STORE;
      8'b?10010??: res = OP_REG_READ;
      8'b0001????: res = OP_EE_WRITE;
      8'b001?????: res = OP_EE_WIPE;
      8'b?0001???: res = OP_EE_READ;
      8'b1001????: res = OP_BULK_WRITE;
      8'b101?????: res = OP_BULK_ERASE;
      default: res = OP_NONE;
    endcase
    return res;
  endfunction

  function automatic logic is_read_op(input logic [7:0] code);
    irsp_op_type op;
    op = decode_op(code);
    return (op == OP_REG_READ) || (op == OP_EE_READ);
  endfunction
endpackage

// ===== hw/irsp_serial_port.sv
// serial slave command port with temperature registers and eeprom words
`timescale 1ns/1ns
`default_nettype none
module irsp_serial_port (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // serial link, host is master
  input wire logic spi_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // measurement side
  input wire logic sample_valid_i,
  input wire logic [11:0] obj_code_i,
  input wire logic [11:0] amb_code_i,
  input wire logic amb_above_max_i,
  input wire logic amb_below_min_i,
  input wire logic ecc_fatal_i,
  // status
  output logic [15:0] obj_temp_o,
  output logic [15:0] amb_temp_o,
  output logic eeprom_unlocked_o,
  output logic charge_pump_en_o
);

  // link domain state
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [irsp_pkg::SHIFT_W-1:0] shift_q;
  logic [irsp_pkg::SHIFT_W-1:0] rx_next;
  logic [7:0] op_q;
  irsp_pkg::irsp_cmd_type cmd_q;
  irsp_pkg::irsp_cmd_type cap_word;
  logic req_q;
  logic ack_l1_q;
  logic ack_l2_q;
  logic sout_q;
  logic [15:0] rsh_q;
  logic rd_op_w;
  logic cap_w;
  logic echo_win;
  logic rd_load;
  logic rd_run;
  logic [15:0] rd_word;

  // system domain state
  logic [2:0] req_s_q;
  logic evt;
  logic ack_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic unlock_q;
  logic pump_q;
  logic fatal_q;
  irsp_pkg::irsp_meas_type obj_q;
  irsp_pkg::irsp_meas_type amb_q;
  irsp_pkg::irsp_meas_type obj_d;
  irsp_pkg::irsp_meas_type amb_d;
  wire logic [irsp_pkg::EE_WORDS-1:0][15:0] ee_q;
  irsp_pkg::irsp_op_type op_w;
  logic [3:0] ee_idx;
  logic ee_hit;
  logic prog_ok;
  logic meas_upd;
  logic store_unlock;
  logic store_pump;
  logic [15:0] reg_rd;
  logic [15:0] ee_rd;

  // link domain
  // bits shift in on rising edges; the device never drives the clock
  assign cnt_d = (cnt_q == irsp_pkg::CNT_MAX) ? cnt_q : cnt_q + 6'h01;
  assign rx_next = {shift_q[irsp_pkg::SHIFT_W-2:0], serial_in_i};
  assign rd_op_w = irsp_pkg::is_read_op(op_q);

  // frame state cleared while chip select is high
  always_ff @(posedge spi_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      cnt_q <= 6'h00;
      shift_q <= '0;
      op_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      shift_q <= rx_next;
      if (cnt_q == irsp_pkg::CNT_OPCODE_LAST) begin
        op_q <= rx_next[7:0];
      end
    end
  end

  // reads issue after the address byte, writes only after all 32 bits
  assign cap_w = (rd_op_w && cnt_q == irsp_pkg::CNT_ADDR_LAST) ||
                 (!rd_op_w && cnt_q == irsp_pkg::CNT_FRAME_LAST);
  assign cap_word = rd_op_w ? {op_q, rx_next[7:0], 16'h0000} : rx_next;

  // command word and request toggle survive chip select
  always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= '0;
      req_q <= 1'b0;
    end else if (cap_w) begin
      cmd_q <= cap_word;
      req_q <= ~req_q;
    end
  end

  // answer toggle from the system side, two flops
  always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_l1_q <= 1'b0;
      ack_l2_q <= 1'b0;
    end else begin
      ack_l1_q <= ack_q;
      ack_l2_q <= ack_l1_q;
    end
  end

  // output windows, counted in rising edges already seen
  assign echo_win = (cnt_q >= irsp_pkg::CNT_ECHO_FIRST && cnt_q <= irsp_pkg::CNT_ADDR_LAST) ||
                    (!rd_op_w && cnt_q >= irsp_pkg::CNT_ADDR_ECHO_FIRST &&
                     cnt_q <= irsp_pkg::CNT_FRAME_LAST);
  assign rd_load = rd_op_w && cnt_q == irsp_pkg::CNT_RD_LOAD;
  assign rd_run = rd_op_w && cnt_q > irsp_pkg::CNT_RD_LOAD && cnt_q <= irsp_pkg::CNT_RD_LAST;
  assign rd_word = (ack_l2_q == req_q) ? rdata_q : 16'h0000;

  // serial_out changes on falling edges so it is stable at rising edges
  always_ff @(negedge spi_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      sout_q <= 1'b0;
      rsh_q <= 16'h0000;
    end else if (rd_load) begin
      sout_q <= rd_word[15];
      rsh_q <= {rd_word[14:0], 1'b0};
    end else if (rd_run) begin
      sout_q <= rsh_q[15];
      rsh_q <= {rsh_q[14:0], 1'b0};
    end else if (echo_win) begin
      sout_q <= shift_q[irsp_pkg::ECHO_TAP];
    end else begin
      sout_q <= 1'b0;
    end
  end

  assign serial_out_o = sout_q;

  // system domain
  assign evt = req_s_q[2] ^ req_s_q[1];
  assign op_w = irsp_pkg::decode_op(cmd_q.op);
  assign ee_idx = cmd_q.addr[3:0];
  assign ee_hit = cmd_q.addr < irsp_pkg::EE_LIMIT;
  assign prog_ok = unlock_q && pump_q;
  assign store_unlock = evt && op_w == irsp_pkg::OP_REG_STORE &&
                        cmd_q.addr == irsp_pkg::ADDR_EE_UNLOCK &&
                        cmd_q.data == irsp_pkg::KEY_EE_UNLOCK;
  assign store_pump = evt && op_w == irsp_pkg::OP_REG_STORE &&
                      cmd_q.addr == irsp_pkg::ADDR_PUMP_CTRL;
  assign meas_upd = sample_valid_i && !unlock_q;

  // forced codes when ambient leaves the calibrated range
  assign amb_d.high = amb_above_max_i;
  assign amb_d.low = amb_below_min_i && !amb_above_max_i;
  assign amb_d.data = amb_d.high ? irsp_pkg::TEMP_ALL_ONES :
                      amb_d.low ? irsp_pkg::TEMP_ALL_ZERO : amb_code_i;
  assign obj_d.high = amb_d.high;
  assign obj_d.low = amb_d.low;
  assign obj_d.data = amb_d.high ? irsp_pkg::TEMP_ALL_ONES :
                      amb_d.low ? irsp_pkg::TEMP_ALL_ZERO : obj_code_i;

  assign obj_temp_o = {obj_q.data, obj_q.high, obj_q.low, fatal_q, 1'b0};
  assign amb_temp_o = {amb_q.data, amb_q.high, amb_q.low, fatal_q, 1'b0};
  assign eeprom_unlocked_o = unlock_q;
  assign charge_pump_en_o = pump_q;

  // read selection
  assign reg_rd = (cmd_q.addr == irsp_pkg::ADDR_OBJ_TEMP) ? obj_temp_o :
                  (cmd_q.addr == irsp_pkg::ADDR_AMB_TEMP) ? amb_temp_o : 16'h0000;
  assign ee_rd = ee_hit ? ee_q[ee_idx] : 16'h0000;
  assign rdata_d = (op_w == irsp_pkg::OP_EE_READ) ? ee_rd : reg_rd;

  // request toggle synchroniser and answer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      req_s_q <= 3'h0;
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      req_s_q <= {req_s_q[1:0], req_q};
      if (evt) begin
        ack_q <= req_s_q[1];
        rdata_q <= rdata_d;
      end
    end
  end

  // control keys; unlock holds until reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      unlock_q <= 1'b0;
      pump_q <= 1'b0;
    end else begin
      if (store_unlock) begin
        unlock_q <= 1'b1;
      end
      if (store_pump) begin
        pump_q <= (cmd_q.data == irsp_pkg::KEY_PUMP_ON);
      end
    end
  end

  // temperature registers and sticky fatal flag
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fatal_q <= 1'b0;
      obj_q <= '0;
      amb_q <= '0;
    end else begin
      if (ecc_fatal_i) begin
        fatal_q <= 1'b1;
      end
      if (meas_upd) begin
        obj_q <= obj_d;
        amb_q <= amb_d;
      end
    end
  end

  // eeprom words, programming only when unlocked with pump on
  for (genvar gi = 0; gi < irsp_pkg::EE_WORDS; gi++) begin : g_ee
    logic sel_w;
    logic wipe_w;
    logic load_w;
    logic [15:0] word_q;
    assign sel_w = ee_hit && ee_idx == 4'(gi);
    assign wipe_w = evt && prog_ok && (op_w == irsp_pkg::OP_BULK_ERASE ||
                    (op_w == irsp_pkg::OP_EE_WIPE && sel_w));
    assign load_w = evt && prog_ok && (op_w == irsp_pkg::OP_BULK_WRITE ||
                    (op_w == irsp_pkg::OP_EE_WRITE && sel_w));
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        word_q <= irsp_pkg::EE_ERASED;
      end else if (wipe_w) begin
        word_q <= irsp_pkg::EE_ERASED;
      end else if (load_w) begin
        word_q <= cmd_q.data;
      end
    end
    assign ee_q[gi] = word_q;
  end

  // assertions
  a_unlock_key_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    store_unlock |=> unlock_q ##1 unlock_q)
    else $error("unlock key did not unlock");

  a_pump_key_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (store_pump && cmd_q.data == irsp_pkg::KEY_PUMP_ON) |=> pump_q)
    else $error("pump key did not enable pump");

  a_frozen_unlocked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    unlock_q |=> $stable(obj_temp_o[15:2]) && $stable(amb_temp_o[15:2]))
    else $error("temperature changed while unlocked");

  a_amb_high_forced: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (meas_upd && amb_above_max_i) |=>
      amb_temp_o[15:4] == irsp_pkg::TEMP_ALL_ONES && amb_temp_o[3])
    else $error("ambient overflow not flagged");

  a_amb_low_forced: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (meas_upd && amb_below_min_i && !amb_above_max_i) |=>
      amb_temp_o[15:4] == irsp_pkg::TEMP_ALL_ZERO && amb_temp_o[2] && !amb_temp_o[3])
    else $error("ambient underflow not flagged");

  a_obj_code_linear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (meas_upd && !amb_above_max_i && !amb_below_min_i) |=>
      obj_temp_o[15:4] == $past(obj_code_i) && obj_temp_o[0] == 1'b0)
    else $error("object code not passed through");

  a_fatal_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ecc_fatal_i |=> (obj_temp_o[1] && amb_temp_o[1]) [*3])
    else $error("fatal flag missing");

  a_ee_locked_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (evt && !prog_ok) |=> $stable(ee_q))
    else $error("eeprom changed while locked");

  a_echo_delay: assert property (@(posedge spi_clk_i) disable iff (chip_select_n_i)
    (cnt_q >= irsp_pkg::CNT_ECHO_FIRST && cnt_q <= irsp_pkg::CNT_ADDR_LAST) |->
      serial_out_o == $past(serial_in_i, 8))
    else $error("echo not delayed by eight clocks");

  a_write_after_32: assert property (@(posedge spi_clk_i) disable iff (chip_select_n_i)
    (!rd_op_w && cnt_q < irsp_pkg::CNT_FRAME_LAST && cnt_q >= irsp_pkg::CNT_ECHO_FIRST) |=>
      $stable(req_q))
    else $error("write issued before full frame");

  a_read_first_bit: assert property (@(posedge spi_clk_i) disable iff (chip_select_n_i)
    (rd_op_w && cnt_q == irsp_pkg::CNT_RD_LOAD && $stable(ack_l2_q) && ack_l2_q == req_q) |->
      serial_out_o == rdata_q[15])
    else $error("read data not at 25th edge");

endmodule
`default_nettype wire

// ===== verif/irsp_host_model.sv
// host master model that clocks command frames into the port
`timescale 1ns/1ns
`default_nettype none
module irsp_host_model (
  // request side
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire irsp_pkg::irsp_cmd_type cmd_i,
  input wire logic [5:0] edges_i,
  output logic done_o,
  output logic [39:0] resp_o,
  // serial link
  output logic spi_clk_o,
  output logic chip_select_n_o,
  output logic serial_in_o,
  input wire logic serial_out_i
);
  logic [39:0] bits_q;
  initial begin
    done_o = 1'b0;
    resp_o = 40'h0;
    spi_clk_o = 1'b0;
    chip_select_n_o = 1'b0;
    serial_in_o = 1'b0;
    // clean rising select edge clears the frame state
    #1 chip_select_n_o = 1'b1;
  end
  // clock only runs inside a frame, 15 ns period
  always @(posedge clk_sys_i) begin
    if (start_i) begin
      done_o = 1'b0;
      resp_o = 40'h0;
      bits_q = {cmd_i, 8'hA5};
      #3 chip_select_n_o = 1'b0;
      for (int i = 0; i < edges_i; i++) begin
        #1 serial_in_o = bits_q[39 - i];
        #7 spi_clk_o = 1'b1;
        resp_o = {resp_o[38:0], serial_out_i};
        #7 spi_clk_o = 1'b0;
      end
      #8 chip_select_n_o = 1'b1;
      serial_in_o = ~serial_in_o;
      #20 done_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_irsp_serial_port.sv
// self-checking bench for the serial command port
`timescale 1ns/1ns
`default_nettype none
module test_irsp_serial_port;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic start = 1'b0;
  irsp_pkg::irsp_cmd_type cmd = 32'h0;
  logic [5:0] edges = 6'h20;
  logic done, sclk, cs_n, sdi, sdo, pump, unl;
  logic [39:0] resp;
  logic valid = 1'b0, hi = 1'b0, lo = 1'b0, fatal = 1'b0;
  logic [11:0] obj = 12'h000, amb = 12'h000;
  logic [15:0] obj_t, amb_t;
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #2 clk = ~clk;
  irsp_serial_port dut (.clk_sys_i(clk), .rst_n_i(rst_n), .spi_clk_i(sclk),
    .chip_select_n_i(cs_n), .serial_in_i(sdi), .serial_out_o(sdo), .sample_valid_i(valid),
    .obj_code_i(obj), .amb_code_i(amb), .amb_above_max_i(hi), .amb_below_min_i(lo),
    .ecc_fatal_i(fatal), .obj_temp_o(obj_t), .amb_temp_o(amb_t), .eeprom_unlocked_o(unl),
    .charge_pump_en_o(pump));
  irsp_host_model host (.clk_sys_i(clk), .start_i(start), .cmd_i(cmd), .edges_i(edges),
    .done_o(done), .resp_o(resp), .spi_clk_o(sclk), .chip_select_n_o(cs_n),
    .serial_in_o(sdi), .serial_out_i(sdo));
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one frame of n serial edges, bounded wait for the host
  task automatic frame(input logic [7:0] op, input logic [7:0] adr, input logic [15:0] dat,
                       input logic [5:0] n);
    int k;
    cmd = {op, adr, dat};
    edges = n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk);
    chk("frame_done", 40'h1, {39'h0, done});
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] adr, input logic [15:0] dat);
    frame(op, adr, dat, 6'h20);
    chk("write_echo", {16'h0, op, adr, dat[15:8]}, resp);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] adr, input logic [15:0] exp);
    frame(op, adr, 16'h0000, 6'h28);
    chk("read_answer", {8'h0, op, 8'h0, exp}, resp);
  endtask
  task automatic load(input logic [11:0] o, input logic [11:0] a, input logic [31:0] exp);
    obj = o;
    amb = a;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    repeat (4) @(negedge clk);
    chk("temp_regs", {8'h0, exp}, {8'h0, obj_t, amb_t});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset_state", 40'h0, {6'h0, unl, pump, obj_t, amb_t});
    load(12'hABC, 12'h123, 32'hABC01230);
    chk("idle_out", 40'h0, {39'h0, sdo});
    rd(8'h48, 8'h09, 16'hABC0);
    rd(8'hC8, 8'h0A, 16'h1230);
    rd(8'h4B, 8'h05, 16'h0000);
    hi = 1'b1;
    load(12'hABC, 12'h123, 32'hFFF8FFF8);
    hi = 1'b0;
    lo = 1'b1;
    load(12'hABC, 12'h123, 32'h00040004);
    lo = 1'b0;
    fatal = 1'b1;
    @(negedge clk);
    fatal = 1'b0;
    load(12'hABC, 12'h123, 32'hABC21232);
    rd(8'h48, 8'h0A, 16'h1232);
    wr(8'h1F, 8'h08, 16'h1234);
    rd(8'h88, 8'h08, 16'h0000);
    frame(8'h50, 8'h10, 16'hB200, 6'h14);
    chk("abort_echo", 40'h0000000501, resp);
    chk("abort_lock", 40'h0, {39'h0, unl});
    wr(8'h50, 8'h10, 16'hB201);
    chk("key_guard", 40'h0, {39'h0, unl});
    wr(8'hD8, 8'h10, 16'hB200);
    chk("unlocked", 40'h1, {39'h0, unl});
    load(12'h555, 12'h666, 32'hABC21232);
    wr(8'h50, 8'h18, 16'h0065);
    chk("pump_on", 40'h1, {39'h0, pump});
    wr(8'h3F, 8'h08, 16'h0000);
    wr(8'h1F, 8'h08, 16'h1234);
    rd(8'h88, 8'h08, 16'h1234);
    wr(8'h1F, 8'h0F, 16'hBEEF);
    rd(8'h08, 8'h0F, 16'hBEEF);
    wr(8'h1F, 8'h10, 16'h4321);
    rd(8'h08, 8'h10, 16'h0000);
    wr(8'h50, 8'h18, 16'h0064);
    chk("pump_off", 40'h0, {39'h0, pump});
    wr(8'h1F, 8'h09, 16'h7777);
    rd(8'h08, 8'h09, 16'h0000);
    wr(8'h50, 8'h18, 16'h0065);
    wr(8'h9F, 8'h00, 16'h5555);
    rd(8'h08, 8'h0F, 16'h5555);
    wr(8'hBF, 8'h00, 16'h0000);
    rd(8'h08, 8'h0F, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
